/* File: rtl/kwh_pkg.sv */
// Purpose: Shared constants and types for the key wakeup halt release block.
// Assumes: 32-bit APB, 12-bit byte addresses, one clock at 40 MHz.
// Notes:   Every offset, bit position, reset value and cycle count lives here.
package kwh_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] KWH_ADDR_KEY_WAKE_EN = 12'hf88;
   localparam logic [11:0] KWH_ADDR_SYS_CTRL    = 12'hf8c;
   localparam logic [11:0] KWH_ADDR_STATUS      = 12'hf90;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int KWH_KEY_EN_LSB    = 4;
   localparam int KWH_KEY_EN_MSB    = 7;
   localparam int KWH_SYS_RELM_BIT  = 0;
   localparam int KWH_SYS_HALT_BIT  = 1;
   localparam int KWH_STS_HALT_BIT  = 0;
   localparam int KWH_STS_WARM_BIT  = 1;
   localparam int KWH_STS_KEY_LSB   = 4;
   localparam int KWH_STS_KEY_MSB   = 7;
   localparam int KWH_STS_REL_BIT   = 8;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [3:0]  KWH_KEY_EN_RST = 4'h0;
   localparam logic        KWH_RELM_RST   = 1'b0;
   localparam logic        KWH_KEY_IDLE   = 1'b1;
   localparam logic        KWH_REL_IDLE   = 1'b0;
   localparam logic [31:0] KWH_RDATA_RST  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int KWH_WARMUP_CYCLES = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      KWH_ST_RUN  = 3'b001,
      KWH_ST_HALT = 3'b010,
      KWH_ST_WARM = 3'b100
   } kwh_state_e;

   typedef struct packed {
      logic       rel;
      logic [3:0] key;
   } kwh_pins_s;

   typedef struct packed {
      logic       relm;
      logic [3:0] key_en;
   } kwh_ctrl_s;

endpackage

/* File: rtl/kwh_sync3.sv */
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_in.
// Notes:   The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module kwh_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Data
   input  wire logic d_in,
   output logic      q_out
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic q_r;

   // The first stage feeds only the second stage, to keep metastability contained.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r  <= RST_VAL;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q_r <= s3_r;
         end
      end
   end

   assign q_out = q_r;

endmodule

/* File: rtl/kwh_warm_timer.sv */
// Purpose: Counts the warm-up period after a halt release.
// Assumes: run_in is held high for the whole warm-up.
// Notes:   done_out pulses in the last cycle of a run of CYCLES cycles.
`timescale 1ns/1ps
module kwh_warm_timer #(
   parameter int CYCLES = 16
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Control
   input  wire logic run_in,
   output logic      done_out
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   localparam logic [W-1:0] ONE  = W'(1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // Counter restarts whenever the warm-up is not running.
   assign cnt_nxt  = run_in ? (cnt_r + ONE) : '0;
   assign done_out = run_in && (cnt_r == LAST);

   // Counter register.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

/* File: rtl/kwh_top.sv */
// Purpose: Key wakeup logic that releases the device from its oscillator-stopped halt.
// Assumes: APB master on MCLK_IN; wake pins are asynchronous and get synchronised here.
// Notes:   RELEASE_REQ_OUT is a gate-only path meant to restart a stopped oscillator.
//
// Functional notes
// - Halt ends when the release pin acts or when any of the four key pins acts.
// - Bits 7 to 4 of the key wakeup enable register enable key pins 3 to 0, one for enabled.
// - The enable bits are write only, reads return zero, and bits 3 to 0 have no function.
// - Reset clears all four key enables so no key pin can wake the device.
// - An enabled key pin releases the halt on low level, and only in level release mode.
// - The release pin acts on high level when the mode bit is one and on a rising edge when it is zero.
// - Entering halt while the release pin is high or an enabled key is low goes straight to warm-up.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module kwh_top (
   // Clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        SRST_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Wake pins
   input  wire logic        RELEASE_PIN_IN,
   input  wire logic [3:0]  KEY_WAKE_PIN_IN,
   // Halt control
   output logic             HALT_OUT,
   output logic             WARMUP_OUT,
   output logic             RELEASE_REQ_OUT
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int WARM_N    = kwh_pkg::KWH_WARMUP_CYCLES;
   // Plain delay length for the warm-up assertion, one less than the period.
   localparam int WARM_LAST = WARM_N - 1;

   kwh_pkg::kwh_state_e state_r;
   kwh_pkg::kwh_state_e state_nxt;
   kwh_pkg::kwh_ctrl_s  ctrl_r;
   kwh_pkg::kwh_ctrl_s  ctrl_nxt;
   kwh_pkg::kwh_pins_s  pins;
   logic                rel_prev_r;
   logic [31:0]         prdata_r;
   logic [31:0]         rd_mux;
   logic                setup_ph;
   logic                access_ph;
   logic                wr_ph;
   logic                hit_key_en;
   logic                hit_sys;
   logic                hit_sts;
   logic                hit_any;
   logic                halt_req;
   logic [3:0]          key_low_en;
   logic                any_key_low;
   logic                rel_rise;
   logic                skip_cond;
   logic                wake_cond;
   logic                st_run;
   logic                st_halt;
   logic                st_warm;
   logic                warm_done;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Key pins idle high, so they reset to high and cannot fake a wake at start-up.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_key
         kwh_sync3 #(.RST_VAL(kwh_pkg::KWH_KEY_IDLE)) u_sync (
            .clk_in (MCLK_IN),
            .rst_in (SRST_IN),
            .d_in   (KEY_WAKE_PIN_IN[gi]),
            .q_out  (pins.key[gi])
         );
      end
   endgenerate

   kwh_sync3 #(.RST_VAL(kwh_pkg::KWH_REL_IDLE)) u_sync_rel (
      .clk_in (MCLK_IN),
      .rst_in (SRST_IN),
      .d_in   (RELEASE_PIN_IN),
      .q_out  (pins.rel)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero wait states; unmapped addresses answer with an error.
   assign setup_ph    = PSEL_IN && !PENABLE_IN;
   assign access_ph   = PSEL_IN && PENABLE_IN;
   assign wr_ph       = access_ph && PWRITE_IN;
   assign hit_key_en  = (PADDR_IN == kwh_pkg::KWH_ADDR_KEY_WAKE_EN);
   assign hit_sys     = (PADDR_IN == kwh_pkg::KWH_ADDR_SYS_CTRL);
   assign hit_sts     = (PADDR_IN == kwh_pkg::KWH_ADDR_STATUS);
   assign hit_any     = hit_key_en || hit_sys || hit_sts;
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = access_ph && !hit_any;
   assign PRDATA_OUT  = prdata_r;

   // Register writes; the halt bit is a command and is never stored.
   // enable bit write
   assign ctrl_nxt.key_en = (wr_ph && hit_key_en) ?
                            PWDATA_IN[kwh_pkg::KWH_KEY_EN_MSB:kwh_pkg::KWH_KEY_EN_LSB] : ctrl_r.key_en;
   assign ctrl_nxt.relm   = (wr_ph && hit_sys) ? PWDATA_IN[kwh_pkg::KWH_SYS_RELM_BIT] : ctrl_r.relm;
   assign halt_req        = wr_ph && hit_sys && PWDATA_IN[kwh_pkg::KWH_SYS_HALT_BIT];

   // Read mux; the enable register gives nothing back, by design of the bus map.
   // write only enables
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_sys) begin
         rd_mux[kwh_pkg::KWH_SYS_RELM_BIT] = ctrl_r.relm;
      end else if (hit_sts) begin
         rd_mux[kwh_pkg::KWH_STS_HALT_BIT] = st_halt;
         rd_mux[kwh_pkg::KWH_STS_WARM_BIT] = st_warm;
         rd_mux[kwh_pkg::KWH_STS_KEY_MSB:kwh_pkg::KWH_STS_KEY_LSB] = pins.key;
         rd_mux[kwh_pkg::KWH_STS_REL_BIT] = pins.rel;
      end
   end

   // Read data is captured in the setup cycle so it is a flop during access.
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         prdata_r <= kwh_pkg::KWH_RDATA_RST;
      end else if (setup_ph && !PWRITE_IN) begin
         prdata_r <= rd_mux;
      end
   end

   // Control registers.
   // enables cleared at reset
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         ctrl_r.key_en <= kwh_pkg::KWH_KEY_EN_RST;
         ctrl_r.relm   <= kwh_pkg::KWH_RELM_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Wake conditions
   // ----------------------------------------------------------------
   // enabled key low
   assign key_low_en  = ctrl_r.key_en & ~pins.key;
   assign any_key_low = |key_low_en;
   assign rel_rise    = pins.rel && !rel_prev_r;
   assign skip_cond   = pins.rel || any_key_low;
   assign wake_cond   = ctrl_r.relm ? (pins.rel || any_key_low) : rel_rise;

   // Async request path: usable while the clock is stopped.
   // gated OR without clock
   assign RELEASE_REQ_OUT = RELEASE_PIN_IN || (ctrl_r.relm && |(ctrl_r.key_en & ~KEY_WAKE_PIN_IN));

   // Previous release pin level for edge detection.
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         rel_prev_r <= kwh_pkg::KWH_REL_IDLE;
      end else begin
         rel_prev_r <= pins.rel;
      end
   end

   // ----------------------------------------------------------------
   // Halt state machine
   // ----------------------------------------------------------------
   assign st_run  = (state_r == kwh_pkg::KWH_ST_RUN);
   assign st_halt = (state_r == kwh_pkg::KWH_ST_HALT);
   assign st_warm = (state_r == kwh_pkg::KWH_ST_WARM);

   // In edge mode keys only block halt entry; a stray low key there cannot end a halt.
   // halt and release sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         kwh_pkg::KWH_ST_RUN: begin
            if (halt_req) begin
               state_nxt = skip_cond ? kwh_pkg::KWH_ST_WARM : kwh_pkg::KWH_ST_HALT;
            end
         end
         kwh_pkg::KWH_ST_HALT: begin
            if (wake_cond) begin
               state_nxt = kwh_pkg::KWH_ST_WARM;
            end
         end
         kwh_pkg::KWH_ST_WARM: begin
            if (warm_done) begin
               state_nxt = kwh_pkg::KWH_ST_RUN;
            end
         end
         default: begin
            state_nxt = kwh_pkg::KWH_ST_RUN;
         end
      endcase
   end

   // State register.
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         state_r <= kwh_pkg::KWH_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   kwh_warm_timer #(.CYCLES(kwh_pkg::KWH_WARMUP_CYCLES)) u_warm (
      .clk_in   (MCLK_IN),
      .rst_in   (SRST_IN),
      .run_in   (st_warm),
      .done_out (warm_done)
   );

   assign HALT_OUT   = st_halt;
   assign WARMUP_OUT = st_warm;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Checked at the edge where reset ends, so the very first edge, with no history yet, is left out.
   AST_KEY_EN_RESET: assert property (@(posedge MCLK_IN)
      ($past(SRST_IN) && !SRST_IN) |-> (ctrl_r.key_en == 4'h0))
      else $error("Key enables not cleared after reset.");

   AST_KEY_EN_READ_ZERO: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (access_ph && !PWRITE_IN && hit_key_en && $past(setup_ph)) |-> (PRDATA_OUT == 32'h0000_0000))
      else $error("Key enable register read returned data.");

   AST_KEY_EN_WRITE: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (wr_ph && hit_key_en) |=> (ctrl_r.key_en == $past(PWDATA_IN[7:4])))
      else $error("Key enable bits not taken from bits 7 to 4.");

   AST_SKIP_HALT: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_run && halt_req && skip_cond) |=> st_warm)
      else $error("Halt entered despite pending wake.");

   AST_ENTER_HALT: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_run && halt_req && !skip_cond) |=> (st_halt && HALT_OUT))
      else $error("Halt command did not halt.");

   AST_LEVEL_KEY_WAKE: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_halt && ctrl_r.relm && any_key_low) |=> st_warm)
      else $error("Enabled low key did not release halt.");

   AST_EDGE_KEY_IGNORED: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_halt && !ctrl_r.relm && !rel_rise) |=> st_halt)
      else $error("Halt left in edge mode without a rising edge.");

   AST_LEVEL_REL_WAKE: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_halt && ctrl_r.relm && pins.rel) |=> st_warm)
      else $error("High release pin did not release halt.");

   AST_EDGE_REL_WAKE: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (st_halt && !ctrl_r.relm && pins.rel && !$past(pins.rel)) |=> st_warm)
      else $error("Rising release edge did not release halt.");

   AST_WARM_LENGTH: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      $rose(st_warm) |-> (st_warm throughout ##WARM_LAST 1'b1) ##1 st_run)
      else $error("Warm-up length wrong.");

   AST_UNMAPPED_ERR: assert property (@(posedge MCLK_IN) disable iff (SRST_IN)
      (access_ph && !hit_any) |-> PSLVERR_OUT)
      else $error("Unmapped access without error.");

   COV_KEY_WAKE: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
      st_halt && ctrl_r.relm && any_key_low ##1 st_warm);
   COV_EDGE_WAKE: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
      st_halt && !ctrl_r.relm && rel_rise ##1 st_warm);
   COV_SKIP: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
      st_run && halt_req && skip_cond);
   COV_FULL_CYCLE: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
      $fell(st_warm) && st_run);

endmodule

/* File: verification/kwh_pin_model.sv */
// Purpose: Behavioural model of the keys and the release switch wired to the wake pins.
// Assumes: Commands come from the bench one at a time, clocked on the rising edge.
// Notes:   Each command lands after a lag of zero to three cycles, so slow keys are seen too.
`timescale 1ns/1ps
module kwh_pin_model (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   // Command from the bench
   input  wire logic                set_in,
   input  wire kwh_pkg::kwh_pins_s  want_in,
   input  wire logic [1:0]          lag_in,
   // Pin levels
   output kwh_pkg::kwh_pins_s       pins_out
);
   logic                lag_r;
   logic [1:0]          cnt_r;
   kwh_pkg::kwh_pins_s  pend_r;

   // -------------------------------------------------------------
   // Pin drive
   // -------------------------------------------------------------
   // Keys idle at their pull-up level and the switch idles low.
   // release idle low
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pins_out <= '{rel: kwh_pkg::KWH_REL_IDLE, key: {4{kwh_pkg::KWH_KEY_IDLE}}};
         lag_r    <= 1'b0;
         cnt_r    <= 2'h0;
         pend_r   <= '{rel: kwh_pkg::KWH_REL_IDLE, key: {4{kwh_pkg::KWH_KEY_IDLE}}};
      end else if (set_in) begin
         pend_r <= want_in;
         cnt_r  <= lag_in;
         lag_r  <= 1'b1;
      end else if (lag_r) begin
         if (cnt_r == 2'h0) begin
            pins_out <= pend_r;
            lag_r    <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end
endmodule

/* File: verification/key_wakeup_halt_release_test.sv */
// Purpose: Self-checking bench for the key wakeup halt release block.
// Assumes: Zero wait state APB slave; pin changes settle within ten cycles.
// Notes:   Expected read results are queued by the driver and compared by a bus monitor.
`timescale 1ns/1ps
module key_wakeup_halt_release_test;
   localparam logic [11:0] A_EN  = kwh_pkg::KWH_ADDR_KEY_WAKE_EN;
   localparam logic [11:0] A_SYS = kwh_pkg::KWH_ADDR_SYS_CTRL;
   localparam logic [11:0] A_STS = kwh_pkg::KWH_ADDR_STATUS;
   logic               mclk = 1'b0;
   logic               srst = 1'b1;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic               halt;
   logic               warm;
   logic               relreq;
   logic               set_r = 1'b0;
   logic [1:0]         lag = 2'h0;
   logic               relm = 1'b0;
   logic [31:0]        seed = 32'had33;
   logic [32:0]        expq[$];
   kwh_pkg::kwh_pins_s want = '{rel: 1'b0, key: 4'hf};
   kwh_pkg::kwh_pins_s pins;
   int                 errors = 0;
   int                 checks = 0;
   int                 cyc = 0;

   // Clock at 40 MHz.
   always #12.5 mclk = ~mclk;

   kwh_top kwh_top_i (.MCLK_IN(mclk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RELEASE_PIN_IN(pins.rel),
      .KEY_WAKE_PIN_IN(pins.key), .HALT_OUT(halt), .WARMUP_OUT(warm), .RELEASE_REQ_OUT(relreq));
   kwh_pin_model kwh_pin_model_i (.clk_in(mclk), .rst_in(srst), .set_in(set_r), .want_in(want),
      .lag_in(lag), .pins_out(pins));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic wrap_up();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t pin level got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t bus value got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; a read leaves its expected {pslverr, prdata} in the queue.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) expq.push_back(e);
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   // Asks the pin model for new levels, then waits for them to settle.
   task automatic drive(input logic r, input logic [3:0] k, input int settle);
      seed = xorshift(seed);
      @(posedge mclk);
      set_r <= 1'b1;
      want <= '{rel: r, key: k};
      lag <= seed[1:0];
      @(posedge mclk);
      set_r <= 1'b0;
      repeat (settle) @(posedge mclk);
      #1;
   endtask

   task automatic halt_go();
      apb(1'b1, A_SYS, {30'h0, 1'b1, relm}, 33'h0);
   endtask

   // Waits for warm-up, then counts how long it stands.
   task automatic warm_run();
      int n;
      int w;
      n = 0;
      w = 0;
      while (warm !== 1'b1 && n < 60) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk_bit(halt, 1'b0);
      while (warm === 1'b1 && w < 60) begin
         @(posedge mclk);
         #1;
         w++;
      end
      chk_bus({1'b0, 32'(w)}, {1'b0, 32'(kwh_pkg::KWH_WARMUP_CYCLES)});
   endtask

   // -------------------------------------------------------------
   // Read monitor and timeout
   // -------------------------------------------------------------
   // Reads are compared at the edge where the master takes the data.
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (expq.size() == 0) begin
            errors++;
            $display("ERROR %0t read with no expectation", $time);
         end else begin
            chk_bus({pslverr, prdata}, expq.pop_front());
         end
      end
   end

   // The whole run needs about 600 cycles, so 6000 means a hang.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         $display("ERROR %0t run did not finish", $time);
         wrap_up();
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      apb(1'b0, A_EN, 32'h0, 33'h0);
      apb(1'b0, A_SYS, 32'h0, 33'h0);
      apb(1'b0, A_STS, 32'h0, {1'b0, 32'h0000_00f0});
      apb(1'b0, 12'hf94, 32'h0, {1'b1, 32'h0});
      seed = xorshift(seed);
      apb(1'b1, A_STS, seed, 33'h0);
      apb(1'b0, A_STS, 32'h0, {1'b0, 32'h0000_00f0});
      relm = 1'b1;
      apb(1'b1, A_SYS, 32'h1, 33'h0);
      apb(1'b0, A_SYS, 32'h0, {1'b0, 32'h1});
      drive(1'b0, 4'h0, 10);
      chk_bit(relreq, 1'b0);
      for (int i = 0; i < 4; i++) begin
         seed = xorshift(seed);
         apb(1'b1, A_EN, {24'h0, 4'h1 << i, seed[3:0]}, 33'h0);
         apb(1'b0, A_EN, 32'h0, 33'h0);
         drive(1'b0, ~(4'h1 << i), 10);
         chk_bit(relreq, 1'b1);
         drive(1'b0, 4'hf ^ (4'h1 << ((i + 1) % 4)), 10);
         chk_bit(relreq, 1'b0);
         drive(1'b0, 4'hf, 10);
         apb(1'b0, A_STS, 32'h0, {1'b0, 32'h0000_00f0});
         halt_go();
         chk_bit(halt, 1'b1);
         drive(1'b0, ~(4'h1 << i), 0);
         warm_run();
         halt_go();
         chk_bit(warm, 1'b1);
         warm_run();
         drive(1'b0, 4'hf, 10);
      end
      drive(1'b1, 4'hf, 10);
      chk_bit(relreq, 1'b1);
      apb(1'b0, A_STS, 32'h0, {1'b0, 32'h0000_01f0});
      halt_go();
      chk_bit(warm, 1'b1);
      warm_run();
      drive(1'b0, 4'hf, 10);
      apb(1'b1, A_EN, 32'h0, 33'h0);
      relm = 1'b0;
      apb(1'b1, A_SYS, 32'h0, 33'h0);
      drive(1'b0, 4'h0, 10);
      chk_bit(relreq, 1'b0);
      halt_go();
      repeat (20) @(posedge mclk);
      #1;
      chk_bit(halt, 1'b1);
      drive(1'b1, 4'h0, 0);
      warm_run();
      halt_go();
      chk_bit(warm, 1'b1);
      warm_run();
      drive(1'b0, 4'hf, 10);
      wrap_up();
   end
endmodule
